// [hdl/ucs_pkg.sv]
// control and status register constants for the serial transceiver core
// assumes an APB master with 32-bit data and a datapath on the same clock
package ucs_pkg;
  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS_FIFO = 8'h00;
  localparam logic [7:0] ADDR_LINE = 8'h04;
  localparam logic [7:0] ADDR_MODEM = 8'h08;
  localparam logic [7:0] ADDR_ENH = 8'h0c;
  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int FCR_EN = 0;
  localparam int FCR_RXCLR = 1;
  localparam int FCR_TXCLR = 2;
  localparam int ENH_BIT = 4;
  localparam logic [7:0] LINE_RST = 8'h00;
  localparam logic [4:0] MODEM_RST = 5'h00;
  localparam logic [1:0] TRIG_RST = 2'h0;
  // ------------------------------------------------------------
  // timeout: four characters plus this many bit times
  // ------------------------------------------------------------
  localparam int TMO_CHARS = 4;
  localparam int TMO_EXTRA_BITS = 12;
  // ------------------------------------------------------------
  // interrupt source codes, status bits 5..0
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    UCS_SRC_LINE = 6'h06,
    UCS_SRC_TMO = 6'h0c,
    UCS_SRC_RECEIVE_DATA_READY_EVENT = 6'h04,
    UCS_SRC_TRANSMIT_SPACE_EVENT = 6'h02,
    UCS_SRC_MODEM = 6'h00,
    UCS_SRC_XOFF = 6'h10,
    UCS_SRC_FLOW = 6'h20,
    UCS_SRC_NONE = 6'h01
  } ucs_src_e;

  // trigger code to fifo level
  function automatic logic [4:0] ucs_trig_level(input logic [1:0] code);
    case (code)
      2'h0: ucs_trig_level = 5'h01;
      2'h1: ucs_trig_level = 5'h04;
      2'h2: ucs_trig_level = 5'h08;
      default: ucs_trig_level = 5'h0e;
    endcase
  endfunction : ucs_trig_level
endpackage : ucs_pkg

// [hdl/ucs_regs.sv]
// control/status registers, interrupt source encoder and rx timeout timer
// assumes datapath strobes are on pclk; cts_n_pin arrives from a pin
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module ucs_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic strobe_bus_mode,
  input wire logic line_status_err,
  input wire logic [4:0] rx_count,
  input wire logic [4:0] tx_count,
  input wire logic rx_char_strobe,
  input wire logic receive_holding_read,
  input wire logic transmit_holding_write,
  input wire logic modem_input_change,
  input wire logic modem_input_status_read,
  input wire logic xoff_match,
  input wire logic xon_match,
  input wire logic special_match,
  input wire logic wake_event,
  input wire logic bit_tick,
  input wire logic cts_n_pin,
  output logic fifo_enable,
  output logic rx_fifo_clear,
  output logic tx_fifo_clear,
  output logic [1:0] rx_trigger,
  output logic [1:0] tx_trigger,
  output logic [1:0] word_length,
  output logic stop_long,
  output logic parity_enable,
  output logic parity_even,
  output logic parity_forced,
  output logic tx_break,
  output logic divisor_select,
  output logic dtr_n,
  output logic rts_n,
  output logic internal_ring_loop_output,
  output logic internal_carrier_loop_output,
  output logic loopback,
  output logic irq,
  output logic irq_oe
);
  // ------------------------------------------------------------
  // apb access decode
  // ------------------------------------------------------------
  logic access;
  logic wr;
  logic rd;
  logic mapped;
  logic [7:0] line_format_control;
  logic [4:0] modem_output_control;
  logic enhanced_feature_enable;
  logic [7:0] interrupt_source_status;
  logic [5:0] next_code;
  logic rx_ready;
  logic pend_tmo;
  logic pend_tx;
  logic pend_xoff;
  logic pend_special;
  logic pend_flow;
  logic pend_wake;
  logic cts_n_meta;
  logic cts_n_sync;
  logic cts_n_prev;
  logic [4:0] tx_count_prev;
  logic [7:0] tmo_cnt;
  logic [7:0] tmo_limit;
  logic tmo_fire;
  logic isr_read;

  assign access = psel & penable & pready;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign isr_read = rd & (paddr == ucs_pkg::ADDR_STATUS_FIFO);

  always_comb
  begin
    if (paddr == ucs_pkg::ADDR_STATUS_FIFO)
      mapped = 1'b1;
    else if (paddr == ucs_pkg::ADDR_LINE)
      mapped = 1'b1;
    else if (paddr == ucs_pkg::ADDR_MODEM)
      mapped = 1'b1;
    else if (paddr == ucs_pkg::ADDR_ENH)
      mapped = 1'b1;
    else
      mapped = 1'b0;
  end

  // zero-wait slave: ready is raised for the access phase only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
        if (paddr == ucs_pkg::ADDR_STATUS_FIFO)
          prdata <= {24'h00_0000, interrupt_source_status};
        else if (paddr == ucs_pkg::ADDR_LINE)
          prdata <= {24'h00_0000, line_format_control};
        else if (paddr == ucs_pkg::ADDR_MODEM)
          prdata <= {27'h000_0000, modem_output_control};
        else if (paddr == ucs_pkg::ADDR_ENH)
          prdata <= {27'h000_0000, enhanced_feature_enable, 4'h0};
        else
          prdata <= 32'h0000_0000;
      end
    end
  end

  // ------------------------------------------------------------
  // fifo control
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fifo_enable <= 1'b0;
      rx_trigger <= ucs_pkg::TRIG_RST;
      tx_trigger <= ucs_pkg::TRIG_RST;
      rx_fifo_clear <= 1'b0;
      tx_fifo_clear <= 1'b0;
    end
    else
    begin
      rx_fifo_clear <= 1'b0;
      tx_fifo_clear <= 1'b0;
      if (wr && paddr == ucs_pkg::ADDR_STATUS_FIFO)
      begin
        // bit 3 is deliberately not stored
        fifo_enable <= pwdata[ucs_pkg::FCR_EN];
        if (pwdata[ucs_pkg::FCR_EN])
        begin
          rx_trigger <= pwdata[7:6];
          rx_fifo_clear <= pwdata[ucs_pkg::FCR_RXCLR];
          tx_fifo_clear <= pwdata[ucs_pkg::FCR_TXCLR];
          if (enhanced_feature_enable)
            tx_trigger <= pwdata[5:4];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // line format, modem control and enhanced enable
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_format_control <= ucs_pkg::LINE_RST;
      modem_output_control <= ucs_pkg::MODEM_RST;
      enhanced_feature_enable <= 1'b0;
    end
    else if (wr)
    begin
      if (paddr == ucs_pkg::ADDR_LINE)
        line_format_control <= pwdata[7:0];
      else if (paddr == ucs_pkg::ADDR_MODEM)
        modem_output_control <= pwdata[4:0];
      else if (paddr == ucs_pkg::ADDR_ENH)
        enhanced_feature_enable <= pwdata[ucs_pkg::ENH_BIT];
    end
  end

  // outputs are flopped copies so every pin comes from a register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      word_length <= 2'h0;
      stop_long <= 1'b0;
      parity_enable <= 1'b0;
      parity_even <= 1'b0;
      parity_forced <= 1'b0;
      tx_break <= 1'b0;
      divisor_select <= 1'b0;
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
      internal_ring_loop_output <= 1'b0;
      internal_carrier_loop_output <= 1'b0;
      loopback <= 1'b0;
      irq_oe <= 1'b0;
    end
    else
    begin
      word_length <= line_format_control[1:0];
      stop_long <= line_format_control[2];
      parity_enable <= line_format_control[3];
      parity_even <= line_format_control[4];
      parity_forced <= line_format_control[5];
      tx_break <= line_format_control[6];
      divisor_select <= line_format_control[7];
      dtr_n <= ~modem_output_control[0];
      rts_n <= ~modem_output_control[1];
      internal_ring_loop_output <= modem_output_control[2] & modem_output_control[4];
      internal_carrier_loop_output <= modem_output_control[3] & modem_output_control[4];
      loopback <= modem_output_control[4];
      irq_oe <= strobe_bus_mode & modem_output_control[3];
    end
  end

  // ------------------------------------------------------------
  // receive timeout timer, counted in bit times
  // ------------------------------------------------------------
  // one-and-a-half stop bits is counted as two; slightly longer wait
  always_comb
  begin
    tmo_limit = 8'(ucs_pkg::TMO_CHARS) * (8'd7 + {6'h00, line_format_control[1:0]}
      + {7'h00, line_format_control[3]} + {7'h00, line_format_control[2]})
      + 8'(ucs_pkg::TMO_EXTRA_BITS);
  end

  assign tmo_fire = bit_tick && (rx_count != 5'h00) && (tmo_cnt == tmo_limit - 8'h01);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tmo_cnt <= 8'h00;
    else if (rx_char_strobe || receive_holding_read || rx_count == 5'h00 || pend_tmo)
      tmo_cnt <= 8'h00;
    else if (bit_tick)
      tmo_cnt <= tmo_cnt + 8'h01;
  end

  // ------------------------------------------------------------
  // sticky pending flags; a set wins over a clear
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cts_n_meta <= 1'b1;
      cts_n_sync <= 1'b1;
      cts_n_prev <= 1'b1;
      tx_count_prev <= 5'h00;
    end
    else
    begin
      cts_n_meta <= cts_n_pin;
      cts_n_sync <= cts_n_meta;
      cts_n_prev <= cts_n_sync;
      tx_count_prev <= tx_count;
    end
  end

  assign rx_ready = fifo_enable ? (rx_count >= ucs_pkg::ucs_trig_level(rx_trigger))
                                : (rx_count != 5'h00);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_tmo <= 1'b0;
    else if (tmo_fire)
      pend_tmo <= 1'b1;
    else if (receive_holding_read)
      pend_tmo <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_tx <= 1'b0;
    else if ((tx_count < ucs_pkg::ucs_trig_level(tx_trigger)
              && tx_count_prev >= ucs_pkg::ucs_trig_level(tx_trigger))
             || (tx_count == 5'h00 && tx_count_prev != 5'h00))
      pend_tx <= 1'b1;
    else if (transmit_holding_write
             || (isr_read && interrupt_source_status[5:0] == ucs_pkg::UCS_SRC_TRANSMIT_SPACE_EVENT))
      pend_tx <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_xoff <= 1'b0;
      pend_special <= 1'b0;
    end
    else
    begin
      if (xoff_match && enhanced_feature_enable)
        pend_xoff <= 1'b1;
      else if (xon_match || (isr_read && interrupt_source_status[4]) || !enhanced_feature_enable)
        pend_xoff <= 1'b0;
      if (special_match && enhanced_feature_enable)
        pend_special <= 1'b1;
      else if (rx_char_strobe || (isr_read && interrupt_source_status[4]) || !enhanced_feature_enable)
        pend_special <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_flow <= 1'b0;
    else if (enhanced_feature_enable && ((cts_n_sync && !cts_n_prev) || (!rts_n && modem_output_control[1] == 1'b0)))
      pend_flow <= 1'b1;
    else if (modem_input_status_read || !enhanced_feature_enable)
      pend_flow <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_wake <= 1'b0;
    else if (wake_event)
      pend_wake <= 1'b1;
    else if (isr_read && interrupt_source_status[5:0] == ucs_pkg::UCS_SRC_NONE)
      pend_wake <= 1'b0;
  end

  // ------------------------------------------------------------
  // priority encoder
  // ------------------------------------------------------------
  always_comb
  begin
    if (line_status_err)
      next_code = ucs_pkg::UCS_SRC_LINE;
    else if (pend_tmo)
      next_code = ucs_pkg::UCS_SRC_TMO;
    else if (rx_ready)
      next_code = ucs_pkg::UCS_SRC_RECEIVE_DATA_READY_EVENT;
    else if (pend_tx)
      next_code = ucs_pkg::UCS_SRC_TRANSMIT_SPACE_EVENT;
    else if (modem_input_change)
      next_code = ucs_pkg::UCS_SRC_MODEM;
    else if (pend_xoff || pend_special)
      next_code = ucs_pkg::UCS_SRC_XOFF;
    else if (pend_flow)
      next_code = ucs_pkg::UCS_SRC_FLOW;
    else
      next_code = ucs_pkg::UCS_SRC_NONE;
  end

  // code is frozen while a status read is in flight so the
  // value read and the flag cleared stay consistent
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      interrupt_source_status <= {2'b00, ucs_pkg::UCS_SRC_NONE};
    else if (!(psel && paddr == ucs_pkg::ADDR_STATUS_FIFO && !pwrite))
      interrupt_source_status <= {fifo_enable, fifo_enable, next_code};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= (next_code != ucs_pkg::UCS_SRC_NONE) & (~strobe_bus_mode | modem_output_control[3]);
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence fcr_enable_wr;
    wr && paddr == ucs_pkg::ADDR_STATUS_FIFO && pwdata[0];
  endsequence

  AST_LINE_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
    line_status_err && !(psel && !pwrite && paddr == ucs_pkg::ADDR_STATUS_FIFO)
    |=> interrupt_source_status[5:0] == 6'h06)
    else $error("line status not reported first");
  AST_TX_CODE: assert property (@(posedge pclk) disable iff (!presetn)
    !psel && pend_tx && !line_status_err && !pend_tmo && !rx_ready
    |=> interrupt_source_status[5:0] == 6'h02)
    else $error("transmit ready code wrong");
  AST_BIT0: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(psel) && !$past(strobe_bus_mode) |-> irq == !interrupt_source_status[0])
    else $error("status bit0 inconsistent with interrupt pin");
  AST_XOFF_ENH: assert property (@(posedge pclk) disable iff (!presetn)
    !enhanced_feature_enable |=> !pend_xoff && !pend_special)
    else $error("xoff flag set without enhanced enable");
  AST_FIFO_BITS: assert property (@(posedge pclk) disable iff (!presetn)
    fifo_enable && !psel |=> interrupt_source_status[7:6] == 2'b11)
    else $error("fifo enable bits not shown");
  AST_RXCLR: assert property (@(posedge pclk) disable iff (!presetn)
    fcr_enable_wr ##0 pwdata[1] |=> rx_fifo_clear ##1 !rx_fifo_clear)
    else $error("receive fifo clear not a single pulse");
  AST_NO_EN_NO_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == ucs_pkg::ADDR_STATUS_FIFO && !pwdata[0] |=> !fifo_enable && !tx_fifo_clear)
    else $error("fifo bits programmed without bit0");
  AST_TX_TRIG: assert property (@(posedge pclk) disable iff (!presetn)
    !enhanced_feature_enable |=> $stable(tx_trigger))
    else $error("transmit trigger changed without enhanced enable");
  AST_DTR: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == ucs_pkg::ADDR_MODEM |=> ##1 dtr_n == !$past(pwdata[0], 2))
    else $error("dtr not inverted");
  AST_BREAK: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == ucs_pkg::ADDR_LINE && pwdata[6] |=> ##1 tx_break)
    else $error("break not driven");
  AST_TMO_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    receive_holding_read && !tmo_fire |=> !pend_tmo)
    else $error("timeout not cleared by holding read");
endmodule : ucs_regs
`default_nettype wire

// [dv/ucs_far_model.sv]
// far-side model: receive/transmit datapath giving fifo counts and event strobes
// assumes it shares pclk with the block and that the bench calls its tasks
`timescale 1ns/10ps
`default_nettype none
module ucs_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rx_fifo_clear,
  input wire logic tx_fifo_clear,
  output logic [4:0] rx_count,
  output logic [4:0] tx_count,
  output logic [7:0] ev,
  output logic bit_tick
);
  logic tick_on = 1'b0;

  initial ev = 8'h00;

  // bit ticks every other cycle, only while the bench lets the line run
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_count <= 5'h00;
      tx_count <= 5'h00;
      bit_tick <= 1'b0;
    end
    else
    begin
      bit_tick <= tick_on & ~bit_tick;
      if (rx_fifo_clear)
        rx_count <= 5'h00;
      if (tx_fifo_clear)
        tx_count <= 5'h00;
    end
  end

  task automatic set_counts(input logic [4:0] r, input logic [4:0] t);
    @(posedge pclk);
    rx_count <= r;
    tx_count <= t;
  endtask : set_counts

  // one-cycle strobe on event line n
  task automatic pulse(input int n);
    @(posedge pclk);
    ev <= 8'h01 << n;
    @(posedge pclk);
    ev <= 8'h00;
  endtask : pulse
endmodule : ucs_far_model
`default_nettype wire

// [dv/tb_top.sv]
// testbench: register and interrupt-source tests of the control/status block
// assumes one 20 MHz clock and a far-side model for counts and event strobes
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; $display("ERROR %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic strobe_bus_mode = 1'b0, line_status_err = 1'b0, modem_input_change = 1'b0, cts_n_pin = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, fifo_enable, rx_fifo_clear, tx_fifo_clear, stop_long, parity_enable, parity_even;
  logic parity_forced, tx_break, divisor_select, dtr_n, rts_n, ring_o, carrier_o, loopback, irq, irq_oe, bit_tick;
  logic [1:0] rx_trigger, tx_trigger, word_length;
  logic [4:0] rx_count, tx_count;
  logic [7:0] ev;
  logic [7:0] rx_clr_n = 8'h00, tx_clr_n = 8'h00;
  logic last_err;
  int bad_count = 0;
  int checks_done = 0;
  localparam logic [7:0] lv [8] = '{8'h03, 8'h2e, 8'h0d, 8'h1a, 8'h3b, 8'h40, 8'h80, 8'h00};
  localparam logic [4:0] mv [3] = '{5'h13, 5'h1c, 5'h0c};

  initial forever #25 pclk = ~pclk;

  ucs_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .strobe_bus_mode(strobe_bus_mode), .line_status_err(line_status_err), .rx_count(rx_count),
    .tx_count(tx_count), .rx_char_strobe(ev[0]), .receive_holding_read(ev[1]),
    .transmit_holding_write(ev[2]), .modem_input_change(modem_input_change),
    .modem_input_status_read(ev[3]), .xoff_match(ev[4]), .xon_match(ev[5]), .special_match(ev[6]),
    .wake_event(ev[7]), .bit_tick(bit_tick), .cts_n_pin(cts_n_pin), .fifo_enable(fifo_enable),
    .rx_fifo_clear(rx_fifo_clear), .tx_fifo_clear(tx_fifo_clear), .rx_trigger(rx_trigger),
    .tx_trigger(tx_trigger), .word_length(word_length), .stop_long(stop_long),
    .parity_enable(parity_enable), .parity_even(parity_even), .parity_forced(parity_forced),
    .tx_break(tx_break), .divisor_select(divisor_select), .dtr_n(dtr_n), .rts_n(rts_n),
    .internal_ring_loop_output(ring_o), .internal_carrier_loop_output(carrier_o),
    .loopback(loopback), .irq(irq), .irq_oe(irq_oe));

  ucs_far_model u_far (.pclk(pclk), .presetn(presetn), .rx_fifo_clear(rx_fifo_clear),
    .tx_fifo_clear(tx_fifo_clear), .rx_count(rx_count), .tx_count(tx_count), .ev(ev), .bit_tick(bit_tick));

  always @(posedge pclk)
  begin
    if (rx_fifo_clear === 1'b1)
      rx_clr_n <= rx_clr_n + 8'h01;
    if (tx_fifo_clear === 1'b1)
      tx_clr_n <= tx_clr_n + 8'h01;
  end

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      bad_count++;
      $display("ERROR %0t no ready", $time);
      wrap_up();
    end
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    apb(1'b1, a, v, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] d;
    apb(1'b0, a, 32'h0, d);
    `CHK(d & m, e)
  endtask : rd_chk

  // let the edge's updates land before looking
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : settle

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    settle(1);
    `CHK({dtr_n, rts_n, fifo_enable, loopback, tx_break, irq, irq_oe}, 7'b1100000)
    rd_chk(ucs_pkg::ADDR_STATUS_FIFO, 32'h01, 32'hffffffff);
    rd_chk(ucs_pkg::ADDR_LINE, 32'h00, 32'hffffffff);
    rd_chk(ucs_pkg::ADDR_MODEM, 32'h00, 32'hffffffff);
    rd_chk(8'h10, 32'h00, 32'hffffffff);
    `CHK(last_err, 1'b1)
    foreach (lv[i])
    begin
      wr(ucs_pkg::ADDR_LINE, {24'h0, lv[i]});
      settle(3);
      `CHK({divisor_select, tx_break, parity_forced, parity_even, parity_enable, stop_long, word_length}, lv[i])
      rd_chk(ucs_pkg::ADDR_LINE, {24'h0, lv[i]}, 32'hffffffff);
    end
    // host keeps modem bit3 clear outside strobe mode
    strobe_bus_mode <= 1'b1;
    foreach (mv[i])
    begin
      wr(ucs_pkg::ADDR_MODEM, {27'h0, mv[i]});
      settle(3);
      `CHK({dtr_n, rts_n, loopback, ring_o, carrier_o}, {~mv[i][0], ~mv[i][1], mv[i][4], mv[i][2] & mv[i][4], mv[i][3] & mv[i][4]})
      rd_chk(ucs_pkg::ADDR_MODEM, {27'h0, mv[i]}, 32'hffffffff);
    end
    settle(2);
    `CHK(irq_oe, 1'b1)
    wr(ucs_pkg::ADDR_MODEM, 32'h0);
    settle(3);
    `CHK(irq_oe, 1'b0)
    @(posedge pclk);
    strobe_bus_mode <= 1'b0;
    // fifo enable, clears and triggers
    wr(ucs_pkg::ADDR_STATUS_FIFO, 32'h01);
    settle(1);
    `CHK(fifo_enable, 1'b1)
    rd_chk(ucs_pkg::ADDR_STATUS_FIFO, 32'hc0, 32'hc0);
    u_far.set_counts(5'h05, 5'h05);
    wr(ucs_pkg::ADDR_STATUS_FIFO, 32'h03);
    settle(3);
    `CHK({rx_clr_n, tx_clr_n, rx_count, tx_count}, {8'd1, 8'd0, 5'h00, 5'h05})
    wr(ucs_pkg::ADDR_STATUS_FIFO, 32'h05);
    settle(3);
    `CHK({rx_clr_n, tx_clr_n, tx_count}, {8'd1, 8'd1, 5'h00})
    wr(ucs_pkg::ADDR_STATUS_FIFO, 32'h06);
    settle(3);
    `CHK({fifo_enable, rx_clr_n, tx_clr_n}, {1'b0, 8'd1, 8'd1})
    rd_chk(ucs_pkg::ADDR_STATUS_FIFO, 32'h00, 32'hc0);
    wr(ucs_pkg::ADDR_ENH, 32'h10);
    for (int c = 0; c < 4; c++)
    begin
      wr(ucs_pkg::ADDR_STATUS_FIFO, {24'h0, c[1:0], c[1:0], 4'h1});
      settle(1);
      `CHK({rx_trigger, tx_trigger}, {c[1:0], c[1:0]})
    end
    wr(ucs_pkg::ADDR_ENH, 32'h00);
    wr(ucs_pkg::ADDR_STATUS_FIFO, 32'h19);
    settle(1);
    `CHK({rx_trigger, tx_trigger, fifo_enable}, 5'b00111)
    wr(ucs_pkg::ADDR_ENH, 32'h10);
    wr(ucs_pkg::ADDR_STATUS_FIFO, 32'h01);
    // interrupt sources and priority
    u_far.set_counts(5'h00, 5'h02);
    settle(3);
    rd_chk(ucs_pkg::ADDR_STATUS_FIFO, 32'h01, 32'h3f);
    rd_chk(ucs_pkg::ADDR_STATUS_FIFO, 32'hc1, 32'hffffffff);
    line_status_err <= 1'b1;
    modem_input_change <= 1'b1;
    u_far.set_counts(5'h01, 5'h02);
    settle(3);
    rd_chk(ucs_pkg::ADDR_STATUS_FIFO, 32'hc6, 32'hffffffff);
    `CHK(irq, 1'b1)
    line_status_err <= 1'b0;
    settle(3);
    rd_chk(ucs_pkg::ADDR_STATUS_FIFO, 32'hc4, 32'hffffffff);
    u_far.tick_on <= 1'b1;
    settle(100);
    rd_chk(ucs_pkg::ADDR_STATUS_FIFO, 32'hcc, 32'hffffffff);
    u_far.tick_on <= 1'b0;
    u_far.pulse(1);
    settle(3);
    rd_chk(ucs_pkg::ADDR_STATUS_FIFO, 32'hc4, 32'hffffffff);
    u_far.set_counts(5'h00, 5'h02);
    settle(3);
    rd_chk(ucs_pkg::ADDR_STATUS_FIFO, 32'hc0, 32'hffffffff);
    u_far.set_counts(5'h00, 5'h00);
    settle(3);
    rd_chk(ucs_pkg::ADDR_STATUS_FIFO, 32'hc2, 32'hffffffff);
    rd_chk(ucs_pkg::ADDR_STATUS_FIFO, 32'hc0, 32'hffffffff);
    modem_input_change <= 1'b0;
    settle(3);
    rd_chk(ucs_pkg::ADDR_STATUS_FIFO, 32'hc1, 32'hffffffff);
    `CHK(irq, 1'b0)
    u_far.set_counts(5'h00, 5'h03);
    u_far.set_counts(5'h00, 5'h00);
    settle(2);
    `CHK(irq, 1'b1)
    u_far.pulse(2);
    settle(3);
    rd_chk(ucs_pkg::ADDR_STATUS_FIFO, 32'hc1, 32'hffffffff);
    u_far.pulse(4);
    settle(3);
    rd_chk(ucs_pkg::ADDR_STATUS_FIFO, 32'hd0, 32'hffffffff);
    rd_chk(ucs_pkg::ADDR_STATUS_FIFO, 32'hc1, 32'hffffffff);
    u_far.pulse(4);
    settle(2);
    `CHK(irq, 1'b1)
    u_far.pulse(5);
    settle(3);
    rd_chk(ucs_pkg::ADDR_STATUS_FIFO, 32'hc1, 32'hffffffff);
    u_far.pulse(6);
    u_far.pulse(0);
    settle(3);
    rd_chk(ucs_pkg::ADDR_STATUS_FIFO, 32'hc1, 32'hffffffff);
    cts_n_pin <= 1'b1;
    settle(6);
    rd_chk(ucs_pkg::ADDR_STATUS_FIFO, 32'he0, 32'hffffffff);
    u_far.pulse(3);
    settle(3);
    rd_chk(ucs_pkg::ADDR_STATUS_FIFO, 32'hc1, 32'hffffffff);
    wr(ucs_pkg::ADDR_ENH, 32'h00);
    u_far.pulse(4);
    settle(3);
    rd_chk(ucs_pkg::ADDR_STATUS_FIFO, 32'hc1, 32'hffffffff);
    u_far.pulse(7);
    settle(3);
    rd_chk(ucs_pkg::ADDR_STATUS_FIFO, 32'hc1, 32'hffffffff);
    wr(ucs_pkg::ADDR_STATUS_FIFO, 32'h00);
    settle(1);
    rd_chk(ucs_pkg::ADDR_STATUS_FIFO, 32'h01, 32'hffffffff);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
